/* core/uscsr_pkg.sv */
// Purpose: shared constants and types for the usb engine control/status block
// Assumes: 8-bit device registers on a 5-bit register address, 32-bit AXI4-Lite words
// Notes:   controller register offsets are byte addresses of aligned words
package uscsr_pkg;

  // device register offsets
  localparam logic [4:0] REG_CLK_EP     = 5'h02;
  localparam logic [4:0] REG_ADDR_WAKE  = 5'h03;
  localparam logic [4:0] REG_HALT       = 5'h04;
  localparam logic [4:0] REG_ENG_STAT   = 5'h05;

  // clock_endpoint_select_ctrl fields
  localparam int unsigned CES_SYSTEM_CLOCK_SELECT_SEL = 6;
  localparam int unsigned CES_SUSP_TEST  = 4;
  localparam int unsigned CES_CLK_EN     = 3;
  localparam int unsigned CES_EP_SEL_LSB = 0;
  localparam logic [7:0]  CES_RST        = 8'h00;

  // device_address_wakeup fields
  localparam int unsigned AWK_ADDR_LSB   = 1;
  localparam int unsigned AWK_WAKE_EN    = 0;
  localparam logic [7:0]  AWK_RST        = 8'h00;

  // endpoint_halt_flags
  localparam int unsigned EP_COUNT       = 6;
  localparam logic [5:0]  HALT_RST       = 6'h3F;
  localparam logic [2:0]  EP_SEL_MAX     = 3'h5;

  // engine_token_status fields
  localparam int unsigned ES_NAK_MASK    = 7;
  localparam int unsigned ES_TXN_DONE    = 6;
  localparam int unsigned ES_XFER_ERR    = 5;
  localparam int unsigned ES_NAK         = 4;
  localparam int unsigned ES_IN          = 3;
  localparam int unsigned ES_OUT         = 2;
  localparam int unsigned ES_EP0_FAULT   = 1;
  localparam int unsigned ES_ADDR_DEFER  = 0;
  localparam logic [7:0]  ES_RST         = 8'h00;

  // pll multiplier towards the 48 MHz bit clock
  localparam logic [3:0]  PLL_MULT_12MHZ = 4'h4;
  localparam logic [3:0]  PLL_MULT_6MHZ  = 4'h8;

  typedef enum logic [1:0] {
    USCSR_TOK_OUT   = 2'h0,
    USCSR_TOK_IN    = 2'h1,
    USCSR_TOK_SETUP = 2'h2,
    USCSR_TOK_SOF   = 2'h3
  } uscsr_tok_t;

  // controller AXI4-Lite register map
  localparam logic [3:0]  CSR_XFER       = 4'h0;
  localparam logic [3:0]  CSR_STATUS     = 4'h4;
  localparam logic [3:0]  CSR_CTRL       = 4'h8;
  localparam int unsigned XFER_WE_BIT    = 16;
  localparam int unsigned XFER_ADDR_LSB  = 8;
  localparam int unsigned ST_BUSY        = 0;
  localparam int unsigned ST_REFUSED     = 1;
  localparam int unsigned ST_GUARD_HIT   = 2;
  localparam int unsigned ST_RDATA_LSB   = 8;
  localparam int unsigned CTRL_AUTO_OFF  = 0;
  localparam logic        CTRL_AUTO_RST  = 1'b1;
  localparam logic [1:0]  AXI_OKAY       = 2'h0;
  localparam logic [1:0]  AXI_SLVERR     = 2'h2;

  typedef enum logic {
    USCSR_CTL_IDLE = 1'b0,
    USCSR_CTL_REQ  = 1'b1
  } uscsr_ctl_state_t;

endpackage

/* core/uscsr_link_if.sv */
// Purpose: register link between the engine registers and their controller
// Assumes: both ends on i_sys_clk; req held until ack
// Notes:   ack is a one-cycle pulse, rdata valid with it
`timescale 1ns/1ps
`default_nettype none
interface uscsr_link_if;
  logic       req;
  logic       we;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic       ack;
  logic [7:0] rdata;

  modport dev (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output ack,
    output rdata
  );

  modport ctl (
    output req,
    output we,
    output addr,
    output wdata,
    input  ack,
    input  rdata
  );
endinterface
`default_nettype wire

/* core/uscsr_dev.sv */
// Purpose: control and status registers of the usb serial engine
// Assumes: engine event inputs are one-cycle pulses on i_sys_clk
// Notes:   registers reached only through the link; unmapped reads return zero
// Function
// - select bit picks 12 or 6 MHz reference
// - test mode turns band-gap off in suspend
// - controller keeps test mode clear while suspended
// - clock enable bit runs or stops usb clock
// - controller stops usb clock after host suspend
// - three-bit select picks endpoint fifo zero..five
// - reserved select codes enable no fifo function
// - seven-bit address in bits seven..one, zero start
// - bit zero enables remote wake-up, resets zero
// - six halt bits, software sets, reset high
// - bus reset clears halts; setup clears ep0
// - nak mask suppresses endpoint zero nak interrupt
// - done flag low during transaction, rises at end
// - crc, pid, token errors set error flag
// - nak flag set when engine answers nak
// - in flag shows current ep0 token is IN
// - out flag on ep0 OUT, not zero length
// - ep0 fifo access error sets fault flag
// - address adopted at once when not deferred
// - deferred address adopted after status IN read
// - unimplemented bits read as zero
`timescale 1ns/1ps
`default_nettype none
module uscsr_dev (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rst_n,
  uscsr_link_if.dev                  link,
  input  wire logic                  i_bus_reset,
  input  wire logic                  i_bus_suspended,
  input  wire logic                  i_tok_valid,
  input  wire uscsr_pkg::uscsr_tok_t i_tok_pid,
  input  wire logic [3:0]            i_tok_ep,
  input  wire logic                  i_txn_end,
  input  wire logic                  i_crc_err,
  input  wire logic                  i_pid_err,
  input  wire logic                  i_token_incomplete,
  input  wire logic                  i_nak_sent,
  input  wire logic                  i_ep0_out_data,
  input  wire logic                  i_ep0_out_zero_len,
  input  wire logic                  i_ep0_fifo_err,
  input  wire logic                  i_status_in_read,
  input  wire logic                  i_ep0_irq_en,
  output logic                       o_ref_is_6mhz,
  output logic [3:0]                 o_pll_mult,
  output logic                       o_suspend_test_mode,
  output logic                       o_bandgap_off,
  output logic                       o_bus_clock_en,
  output logic [2:0]                 o_ep_sel,
  output logic                       o_ep_sel_valid,
  output logic [5:0]                 o_ep_fifo_sel,
  output logic [6:0]                 o_device_address,
  output logic                       o_remote_wakeup_en,
  output logic [5:0]                 o_ep_halt,
  output logic                       o_ep0_nak_irq
);

  logic       ack_r;
  logic [7:0] rdata_r;
  logic       take;
  logic       wr_ces;
  logic       wr_awk;
  logic       wr_halt;
  logic       wr_es;
  logic       setup_ep0;
  logic       ep0_tok;
  logic [7:0] rd_mux;

  logic       system_clock_select_sel_r;
  logic       susp_test_r;
  logic       clk_en_r;
  logic [2:0] ep_sel_r;
  logic [7:0] awk_r;
  logic [6:0] act_addr_r;
  logic       addr_pend_r;
  logic [5:0] halt_r;
  logic [5:0] halt_nxt;
  logic       nak_mask_r;
  logic       txn_done_r;
  logic       xfer_err_r;
  logic       nak_r;
  logic       in_r;
  logic       out_r;
  logic       fault_r;
  logic       defer_r;
  logic [5:0] ep_onehot;

  // one request per req assertion: ack blocks the retake while req is still high
  assign take      = link.req & ~ack_r;
  assign wr_ces    = take & link.we & (link.addr == uscsr_pkg::REG_CLK_EP);
  assign wr_awk    = take & link.we & (link.addr == uscsr_pkg::REG_ADDR_WAKE);
  assign wr_halt   = take & link.we & (link.addr == uscsr_pkg::REG_HALT);
  assign wr_es     = take & link.we & (link.addr == uscsr_pkg::REG_ENG_STAT);
  assign ep0_tok   = i_tok_valid & (i_tok_ep == 4'h0);
  assign setup_ep0 = ep0_tok & (i_tok_pid == uscsr_pkg::USCSR_TOK_SETUP);

  always_comb
  begin
    rd_mux = 8'h00;
    unique case (link.addr)
      uscsr_pkg::REG_CLK_EP:
      begin
        rd_mux[uscsr_pkg::CES_SYSTEM_CLOCK_SELECT_SEL] = system_clock_select_sel_r;
        rd_mux[uscsr_pkg::CES_SUSP_TEST]  = susp_test_r;
        rd_mux[uscsr_pkg::CES_CLK_EN]     = clk_en_r;
        rd_mux[2:0]                       = ep_sel_r;
      end
      uscsr_pkg::REG_ADDR_WAKE: rd_mux = awk_r;
      uscsr_pkg::REG_HALT:      rd_mux = {2'h0, halt_r};
      uscsr_pkg::REG_ENG_STAT:
        rd_mux = {nak_mask_r, txn_done_r, xfer_err_r, nak_r, in_r, out_r, fault_r, defer_r};
      default:                  rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      ack_r   <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      ack_r <= take;
      if (take && !link.we)
        rdata_r <= rd_mux;
    end
  end

  assign link.ack   = ack_r;
  assign link.rdata = rdata_r;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      system_clock_select_sel_r <= uscsr_pkg::CES_RST[uscsr_pkg::CES_SYSTEM_CLOCK_SELECT_SEL];
      susp_test_r  <= uscsr_pkg::CES_RST[uscsr_pkg::CES_SUSP_TEST];
      clk_en_r     <= uscsr_pkg::CES_RST[uscsr_pkg::CES_CLK_EN];
      ep_sel_r     <= uscsr_pkg::CES_RST[2:0];
    end
    else if (wr_ces)
    begin
      system_clock_select_sel_r <= link.wdata[uscsr_pkg::CES_SYSTEM_CLOCK_SELECT_SEL];
      susp_test_r  <= link.wdata[uscsr_pkg::CES_SUSP_TEST];
      clk_en_r     <= link.wdata[uscsr_pkg::CES_CLK_EN];
      ep_sel_r     <= link.wdata[2:0];
    end
  end

  assign o_ref_is_6mhz       = system_clock_select_sel_r;
  assign o_pll_mult          = system_clock_select_sel_r ? uscsr_pkg::PLL_MULT_6MHZ : uscsr_pkg::PLL_MULT_12MHZ;
  assign o_suspend_test_mode = susp_test_r;
  // band-gap only drops while suspended; outside suspend the bit has no effect
  assign o_bandgap_off       = susp_test_r & i_bus_suspended;
  assign o_bus_clock_en      = clk_en_r;
  assign o_ep_sel            = ep_sel_r;
  assign o_ep_sel_valid      = (ep_sel_r <= uscsr_pkg::EP_SEL_MAX);

  always_comb
  begin
    ep_onehot = 6'h00;
    for (int i = 0; i < uscsr_pkg::EP_COUNT; i++)
      if (ep_sel_r == i[2:0])
        ep_onehot[i] = 1'b1;
  end

  // 11x matches no bit, so no fifo path is opened
  assign o_ep_fifo_sel = ep_onehot;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      awk_r       <= uscsr_pkg::AWK_RST;
      act_addr_r  <= uscsr_pkg::AWK_RST[7:1];
      addr_pend_r <= 1'b0;
    end
    else if (wr_awk)
    begin
      awk_r <= link.wdata;
      if (!defer_r)
      begin
        act_addr_r  <= link.wdata[7:1];
        addr_pend_r <= 1'b0;
      end
      else
        addr_pend_r <= 1'b1;
    end
    else if (i_status_in_read && addr_pend_r)
    begin
      act_addr_r  <= awk_r[7:1];
      addr_pend_r <= 1'b0;
    end
  end

  assign o_device_address   = act_addr_r;
  assign o_remote_wakeup_en = awk_r[uscsr_pkg::AWK_WAKE_EN];

  // hardware clears beat a software write in the same cycle: a stale halt must not survive setup
  always_comb
  begin
    halt_nxt = wr_halt ? link.wdata[5:0] : halt_r;
    if (setup_ep0)
      halt_nxt[0] = 1'b0;
    if (i_bus_reset)
      halt_nxt = 6'h00;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      halt_r <= uscsr_pkg::HALT_RST;
    else
      halt_r <= halt_nxt;
  end

  assign o_ep_halt = halt_r;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      nak_mask_r <= uscsr_pkg::ES_RST[uscsr_pkg::ES_NAK_MASK];
      defer_r    <= uscsr_pkg::ES_RST[uscsr_pkg::ES_ADDR_DEFER];
    end
    else if (wr_es)
    begin
      nak_mask_r <= link.wdata[uscsr_pkg::ES_NAK_MASK];
      defer_r    <= link.wdata[uscsr_pkg::ES_ADDR_DEFER];
    end
  end

  // sticky flags: a hardware set in the clearing cycle wins
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      xfer_err_r <= uscsr_pkg::ES_RST[uscsr_pkg::ES_XFER_ERR];
      fault_r    <= uscsr_pkg::ES_RST[uscsr_pkg::ES_EP0_FAULT];
      out_r      <= uscsr_pkg::ES_RST[uscsr_pkg::ES_OUT];
    end
    else
    begin
      xfer_err_r <= (i_crc_err | i_pid_err | i_token_incomplete) |
                    (wr_es ? link.wdata[uscsr_pkg::ES_XFER_ERR] : xfer_err_r);
      fault_r    <= i_ep0_fifo_err | (wr_es ? link.wdata[uscsr_pkg::ES_EP0_FAULT] : fault_r);
      if (i_ep0_out_data && !i_ep0_out_zero_len)
        out_r <= 1'b1;
      else if (setup_ep0)
        out_r <= 1'b0;
      else if (wr_es)
        out_r <= link.wdata[uscsr_pkg::ES_OUT];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      txn_done_r <= uscsr_pkg::ES_RST[uscsr_pkg::ES_TXN_DONE];
      nak_r      <= uscsr_pkg::ES_RST[uscsr_pkg::ES_NAK];
      in_r       <= uscsr_pkg::ES_RST[uscsr_pkg::ES_IN];
    end
    else
    begin
      if (i_txn_end)
        txn_done_r <= 1'b1;
      else if (i_tok_valid)
        txn_done_r <= 1'b0;
      if (i_nak_sent)
        nak_r <= 1'b1;
      else if (i_tok_valid)
        nak_r <= 1'b0;
      if (i_tok_valid)
        in_r <= ep0_tok & (i_tok_pid == uscsr_pkg::USCSR_TOK_IN);
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      o_ep0_nak_irq <= 1'b0;
    else
      o_ep0_nak_irq <= i_nak_sent & (i_tok_ep == 4'h0) & ~nak_mask_r & i_ep0_irq_en;
  end

endmodule
`default_nettype wire

/* core/uscsr_ctl.sv */
// Purpose: controller end: AXI4-Lite orders turned into link register accesses
// Assumes: i_bus_suspended comes from logic on i_sys_clk
// Notes:   one link access at a time; extra orders while busy are refused
`timescale 1ns/1ps
`default_nettype none
module uscsr_ctl (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  uscsr_link_if.ctl        link,
  input  wire logic        i_bus_suspended,
  input  wire logic [3:0]  i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [3:0]  i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready
);

  uscsr_pkg::uscsr_ctl_state_t st_r;
  logic        aw_got_r;
  logic [3:0]  aw_addr_r;
  logic        w_got_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        do_wr;
  logic        wr_xfer;
  logic        wr_stat;
  logic        wr_ctrl;
  logic        busy;
  logic        cmd_we_r;
  logic [4:0]  cmd_addr_r;
  logic [7:0]  cmd_data_r;
  logic [7:0]  last_rd_r;
  logic [7:0]  shadow_r;
  logic        refused_r;
  logic        guard_r;
  logic        auto_en_r;
  logic        auto_pend_r;
  logic        susp_q_r;
  logic        sw_start;
  logic        auto_start;
  logic        guard_now;
  logic [31:0] rd_word;

  assign o_s_axi_awready = ~aw_got_r & ~o_s_axi_bvalid;
  assign o_s_axi_wready  = ~w_got_r & ~o_s_axi_bvalid;
  assign do_wr           = aw_got_r & w_got_r & ~o_s_axi_bvalid;
  assign wr_xfer         = do_wr & (aw_addr_r == uscsr_pkg::CSR_XFER);
  assign wr_stat         = do_wr & (aw_addr_r == uscsr_pkg::CSR_STATUS) & w_strb_r[0];
  assign wr_ctrl         = do_wr & (aw_addr_r == uscsr_pkg::CSR_CTRL) & w_strb_r[0];
  assign busy            = (st_r == uscsr_pkg::USCSR_CTL_REQ) | auto_pend_r;
  assign auto_start      = (st_r == uscsr_pkg::USCSR_CTL_IDLE) & auto_pend_r;
  assign sw_start        = wr_xfer & ~busy;
  // test mode may not be raised while the bus sleeps
  assign guard_now       = i_bus_suspended & w_data_r[uscsr_pkg::XFER_WE_BIT] &
                           (w_data_r[12:8] == uscsr_pkg::REG_CLK_EP) &
                           w_data_r[uscsr_pkg::CES_SUSP_TEST];

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      aw_got_r       <= 1'b0;
      aw_addr_r      <= 4'h0;
      w_got_r        <= 1'b0;
      w_data_r       <= 32'h0000_0000;
      w_strb_r       <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp  <= uscsr_pkg::AXI_OKAY;
    end
    else
    begin
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_got_r  <= 1'b1;
        w_data_r <= i_s_axi_wdata;
        w_strb_r <= i_s_axi_wstrb;
      end
      if (do_wr)
      begin
        aw_got_r       <= 1'b0;
        w_got_r        <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= (aw_addr_r == uscsr_pkg::CSR_XFER || aw_addr_r == uscsr_pkg::CSR_STATUS ||
                           aw_addr_r == uscsr_pkg::CSR_CTRL) ? uscsr_pkg::AXI_OKAY : uscsr_pkg::AXI_SLVERR;
      end
      else if (o_s_axi_bvalid && i_s_axi_bready)
        o_s_axi_bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (i_s_axi_araddr)
      uscsr_pkg::CSR_XFER:
        rd_word = {15'h0000, cmd_we_r, 3'h0, cmd_addr_r, cmd_data_r};
      uscsr_pkg::CSR_STATUS:
      begin
        rd_word[uscsr_pkg::ST_BUSY]      = busy;
        rd_word[uscsr_pkg::ST_REFUSED]   = refused_r;
        rd_word[uscsr_pkg::ST_GUARD_HIT] = guard_r;
        rd_word[15:8]                    = last_rd_r;
      end
      uscsr_pkg::CSR_CTRL:
        rd_word[uscsr_pkg::CTRL_AUTO_OFF] = auto_en_r;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata  <= 32'h0000_0000;
      o_s_axi_rresp  <= uscsr_pkg::AXI_OKAY;
    end
    else if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      o_s_axi_rvalid <= 1'b1;
      o_s_axi_rdata  <= rd_word;
      o_s_axi_rresp  <= (i_s_axi_araddr == uscsr_pkg::CSR_XFER || i_s_axi_araddr == uscsr_pkg::CSR_STATUS ||
                         i_s_axi_araddr == uscsr_pkg::CSR_CTRL) ? uscsr_pkg::AXI_OKAY : uscsr_pkg::AXI_SLVERR;
    end
    else if (o_s_axi_rvalid && i_s_axi_rready)
      o_s_axi_rvalid <= 1'b0;
  end

  assign o_s_axi_arready = ~o_s_axi_rvalid;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      refused_r <= 1'b0;
      guard_r   <= 1'b0;
      auto_en_r <= uscsr_pkg::CTRL_AUTO_RST;
    end
    else
    begin
      refused_r <= (wr_xfer & busy) | ((wr_stat & w_data_r[uscsr_pkg::ST_REFUSED]) ? 1'b0 : refused_r);
      guard_r   <= (sw_start & guard_now) | ((wr_stat & w_data_r[uscsr_pkg::ST_GUARD_HIT]) ? 1'b0 : guard_r);
      if (wr_ctrl)
        auto_en_r <= w_data_r[uscsr_pkg::CTRL_AUTO_OFF];
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      susp_q_r    <= 1'b0;
      auto_pend_r <= 1'b0;
    end
    else
    begin
      susp_q_r <= i_bus_suspended;
      if (i_bus_suspended && !susp_q_r && auto_en_r)
        auto_pend_r <= 1'b1;
      else if (auto_start)
        auto_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      st_r       <= uscsr_pkg::USCSR_CTL_IDLE;
      cmd_we_r   <= 1'b0;
      cmd_addr_r <= 5'h00;
      cmd_data_r <= 8'h00;
      last_rd_r  <= 8'h00;
      shadow_r   <= uscsr_pkg::CES_RST;
    end
    else
    begin
      unique case (st_r)
        uscsr_pkg::USCSR_CTL_IDLE:
          if (auto_start)
          begin
            st_r       <= uscsr_pkg::USCSR_CTL_REQ;
            cmd_we_r   <= 1'b1;
            cmd_addr_r <= uscsr_pkg::REG_CLK_EP;
            cmd_data_r <= shadow_r & ~8'h18;
          end
          else if (sw_start)
          begin
            st_r       <= uscsr_pkg::USCSR_CTL_REQ;
            cmd_we_r   <= w_data_r[uscsr_pkg::XFER_WE_BIT];
            cmd_addr_r <= w_data_r[12:8];
            cmd_data_r <= guard_now ? (w_data_r[7:0] & ~8'h10) : w_data_r[7:0];
          end
        uscsr_pkg::USCSR_CTL_REQ:
          if (link.ack)
          begin
            st_r <= uscsr_pkg::USCSR_CTL_IDLE;
            if (!cmd_we_r)
              last_rd_r <= link.rdata;
            if (cmd_addr_r == uscsr_pkg::REG_CLK_EP)
              shadow_r <= cmd_we_r ? cmd_data_r : link.rdata;
          end
      endcase
    end
  end

  assign link.req   = (st_r == uscsr_pkg::USCSR_CTL_REQ);
  assign link.we    = cmd_we_r;
  assign link.addr  = cmd_addr_r;
  assign link.wdata = cmd_data_r;

endmodule
`default_nettype wire

/* verif/uscsr_asserts.sv */
// Purpose: link protocol and readback checks between controller and engine registers
// Assumes: one clock domain, synchronous active-low reset
// Notes:   watches only the shared link signals
`timescale 1ns/1ps
`default_nettype none
module uscsr_asserts (
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  input wire logic       req,
  input wire logic       we,
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  AST_ACK_NEXT: assert property (req && !ack |=> ack) else $error("link ack late");
  AST_ACK_PULSE: assert property (ack |=> !ack) else $error("link ack held");
  AST_ACK_CAUSE: assert property (ack |-> $past(req)) else $error("link ack without request");
  AST_REQ_HOLD: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("link request changed before ack");
  AST_REQ_DROP: assert property (ack |=> !req) else $error("link request kept after ack");
  AST_CLK_RSV: assert property (ack && !we && addr == uscsr_pkg::REG_CLK_EP |-> rdata[7] == 1'b0 && rdata[5] == 1'b0)
    else $error("clock select unused bits set");
  AST_HALT_RSV: assert property (ack && !we && addr == uscsr_pkg::REG_HALT |-> rdata[7:6] == 2'h0)
    else $error("halt unused bits set");
  AST_UNMAPPED: assert property (ack && !we && (addr < uscsr_pkg::REG_CLK_EP || addr > uscsr_pkg::REG_ENG_STAT)
    |-> rdata == 8'h00) else $error("unmapped read not zero");
endmodule
`default_nettype wire

/* verif/tb.sv */
// Purpose: self-checking bench, controller and engine registers joined by the link
// Assumes: AXI4-Lite master in the bench, one access at a time
// Notes:   event pulses come from one vector so each source is reachable
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic [10:0]           ev = 11'h000;
  uscsr_pkg::uscsr_tok_t pid = uscsr_pkg::USCSR_TOK_SETUP;
  logic [3:0]            tep = 4'h0;
  logic [3:0]            awaddr = 4'h0;
  logic [3:0]            araddr = 4'h0;
  logic                  awvalid = 1'b0;
  logic                  wvalid = 1'b0;
  logic                  bready = 1'b0;
  logic                  arvalid = 1'b0;
  logic                  rready = 1'b0;
  logic [31:0]           wdat = 32'h0;
  logic [31:0]           rdat;
  logic                  awready, wready, bvalid, arready, rvalid, irq;
  logic [5:0]            fsel, halt;
  logic [6:0]            dadr;
  logic [7:0]            v, e;
  int                    n_mismatch = 0;
  int                    comparisons = 0;
  // rows: register, value written, value read back
  logic [20:0]           rows [7] = '{21'h02FF5F, 21'h024D4D, 21'h03A7A7, 21'h04FF3F, 21'h058080,
                                      21'h1FFF00, 21'h050000};
  uscsr_link_if link ();
  always #4 clk = ~clk;
  uscsr_dev u_uscsr_dev (.i_sys_clk(clk), .i_rst_n(rst_n), .link(link), .i_bus_reset(ev[0]),
    .i_bus_suspended(1'b0), .i_tok_valid(ev[1]), .i_tok_pid(pid), .i_tok_ep(tep), .i_txn_end(ev[2]),
    .i_crc_err(ev[3]), .i_pid_err(ev[4]), .i_token_incomplete(ev[5]), .i_nak_sent(ev[6]),
    .i_ep0_out_data(ev[7]), .i_ep0_out_zero_len(ev[8]), .i_ep0_fifo_err(ev[9]), .i_status_in_read(ev[10]),
    .i_ep0_irq_en(1'b1), .o_ref_is_6mhz(), .o_pll_mult(), .o_suspend_test_mode(), .o_bandgap_off(),
    .o_bus_clock_en(), .o_ep_sel(), .o_ep_sel_valid(), .o_ep_fifo_sel(fsel), .o_device_address(dadr),
    .o_remote_wakeup_en(), .o_ep_halt(halt), .o_ep0_nak_irq(irq));
  uscsr_ctl u_uscsr_ctl (.i_sys_clk(clk), .i_rst_n(rst_n), .link(link), .i_bus_suspended(1'b0),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdat),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdat), .o_s_axi_rresp(), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready));
  uscsr_asserts u_uscsr_asserts (.i_sys_clk(clk), .i_rst_n(rst_n), .req(link.req), .we(link.we),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
  task results;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    begin
      comparisons++;
      if (g !== x)
      begin
        n_mismatch++;
        $display("wrong value %s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  task tmo(input int n);
    if (n >= 60)
    begin
      n_mismatch++;
      results;
    end
  endtask
  task axw(input logic [3:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge clk);
      awaddr <= a;
      wdat <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do
      begin
        @(posedge clk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        n++;
      end
      while (bvalid !== 1'b1 && n < 60);
      tmo(n);
      bready <= 1'b0;
    end
  endtask
  task axr(input logic [3:0] a, output logic [31:0] q);
    int n;
    begin
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do
      begin
        @(posedge clk);
        if (arready) arvalid <= 1'b0;
        n++;
      end
      while (rvalid !== 1'b1 && n < 60);
      tmo(n);
      q = rdat;
      rready <= 1'b0;
    end
  endtask
  // one engine register access through the controller, polled until idle
  task dacc(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] s;
    int n;
    begin
      axw(uscsr_pkg::CSR_XFER, {15'h0000, w, 3'h0, a, d});
      n = 0;
      do
      begin
        axr(uscsr_pkg::CSR_STATUS, s);
        n++;
      end
      while (s[uscsr_pkg::ST_BUSY] !== 1'b0 && n < 60);
      tmo(n);
      q = s[15:8];
    end
  endtask
  task pulse(input int b);
    begin
      @(posedge clk);
      ev <= 11'h001 << b;
      @(posedge clk);
      ev <= 11'h000;
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      dacc(1'b1, rows[i][20:16], rows[i][15:8], v);
      dacc(1'b0, rows[i][20:16], 8'h00, v);
      chk("readback", rows[i][7:0], v);
      $display("row %0d done", i);
    end
    chk("address now", 8'h53, {1'b0, dadr});
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    chk("halt reset", 8'h3F, {2'h0, halt});
    chk("address reset", 8'h00, {1'b0, dadr});
    dacc(1'b0, uscsr_pkg::REG_ENG_STAT, 8'h00, v);
    chk("status reset", 8'h00, v);
    $display("reset test done");
    for (int c = 0; c < 8; c++)
    begin
      e = (c < 6) ? (8'h01 << c) : 8'h00;
      dacc(1'b1, uscsr_pkg::REG_CLK_EP, 8'(c), v);
      chk("fifo select", e, {2'h0, fsel});
    end
    $display("select test done");
    for (int b = 3; b < 6; b++)
    begin
      pulse(b);
      dacc(1'b0, uscsr_pkg::REG_ENG_STAT, 8'h00, v);
      chk("error flag", 8'h20, v & 8'h20);
      dacc(1'b1, uscsr_pkg::REG_ENG_STAT, 8'h00, v);
      dacc(1'b0, uscsr_pkg::REG_ENG_STAT, 8'h00, v);
      chk("error clear", 8'h00, v & 8'h20);
    end
    $display("error test done");
    pulse(1);
    dacc(1'b0, uscsr_pkg::REG_HALT, 8'h00, v);
    chk("halt after setup", 8'h3E, v);
    pulse(0);
    #1;
    chk("halt after bus reset", 8'h00, {2'h0, halt});
    $display("halt test done");
    for (int i = 0; i < 3; i++)
    begin
      dacc(1'b1, uscsr_pkg::REG_ENG_STAT, {i == 1, 7'h00}, v);
      tep <= (i == 2) ? 4'h1 : 4'h0;
      pulse(6);
      #1;
      chk("nak interrupt", {7'h00, i == 0}, {7'h00, irq});
    end
    dacc(1'b0, uscsr_pkg::REG_ENG_STAT, 8'h00, v);
    chk("nak flag", 8'h10, v & 8'h10);
    $display("nak test done");
    dacc(1'b1, uscsr_pkg::REG_ENG_STAT, 8'h01, v);
    dacc(1'b1, uscsr_pkg::REG_ADDR_WAKE, 8'h2A, v);
    chk("address held", 8'h00, {1'b0, dadr});
    pulse(10);
    #1;
    chk("address adopted", 8'h15, {1'b0, dadr});
    $display("deferred address test done");
    pulse(2);
    pulse(7);
    pulse(9);
    dacc(1'b0, uscsr_pkg::REG_ENG_STAT, 8'h00, v);
    chk("event flags", 8'h46, v & 8'h46);
    results;
  end
endmodule
`default_nettype wire
